// [baud_gen_map.svh]
`ifndef BAUD_GEN_MAP_SVH
`define BAUD_GEN_MAP_SVH

// byte addresses of the register words
`define BG_OFF_DIV_LOW      8'h00
`define BG_OFF_DIV_HIGH     8'h04
`define BG_OFF_CONTROL      8'h08
`define BG_OFF_STATUS       8'h0C
`define BG_OFF_TICKS        8'h10
`define BG_OFF_DIV_USED     8'h14

// control word fields
`define BG_CTL_SYNC_BIT     0
`define BG_CTL_FAST_BIT     1
`define BG_CTL_WIDE_BIT     2
`define BG_CTL_MASTER_BIT   3
`define BG_CTL_WIDTH        4

// status word fields
`define BG_STA_CLK_BIT      0
`define BG_STA_PHASE_BIT    1
`define BG_STA_CNT_LSB      16

// reset values
`define BG_RST_DIV_LOW      8'h00
`define BG_RST_DIV_HIGH     8'h00
`define BG_RST_CONTROL      4'h0

// half of each prescale factor, minus one
`define BG_HALF_64          5'h1F
`define BG_HALF_16          5'h07
`define BG_HALF_4           5'h01

// axi responses
`define BG_RESP_OKAY        2'h0
`define BG_RESP_SLVERR      2'h2

`endif

// [baud_gen_pkg.sv]
package baud_gen_pkg;

    // prescale factor applied after the divisor counter, one-hot
    typedef enum logic [2:0] {
        presc_64 = 3'b001,
        presc_16 = 3'b010,
        presc_4  = 3'b100
    } presc_t;

    // where the shift clock comes from
    typedef enum logic [2:0] {
        clk_none   = 3'b001,
        clk_master = 3'b010,
        clk_slave  = 3'b100
    } clk_src_t;

endpackage

// [pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    input  wire logic aclk,     // system clock
    input  wire logic aresetn,  // synchronous reset, active low
    input  wire logic pin_in,   // asynchronous level
    output logic      pin_sync  // level after two flops
);

    logic stage1_r;
    logic stage2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
        end
    end

    assign pin_sync = stage2_r;

endmodule

`default_nettype wire

// [tick_divider.sv]
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter int W = 16
) (
    input  wire logic         aclk,     // system clock
    input  wire logic         aresetn,  // synchronous reset, active low
    input  wire logic         restart,  // clear the count
    input  wire logic         enable,   // count this cycle
    input  wire logic [W-1:0] limit,    // period minus one
    output logic              tick,     // one pulse per limit+1 enables
    output logic      [W-1:0] count     // current count
);

    initial begin
        if (W < 1 || W > 16) begin
            $error("tick_divider width out of range");
        end
    end

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire          at_end = (cnt_r >= limit);

    assign tick  = enable & at_end & ~restart;
    assign count = cnt_r;

    assign cnt_nxt = restart ? '0 :
                     !enable ? cnt_r :
                     at_end  ? '0 : W'(cnt_r + 1'b1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

`default_nettype wire

// [baud_gen.sv]
// Overview of operation
// [RULE1] low divisor register holds bits 7..0
// [RULE2] high divisor register holds bits 15..8
// [RULE3] writing low byte restarts divisor counter
// [RULE4] writing high byte restarts divisor counter
// [RULE5] narrow divisor ignores high byte always
// [RULE6] async narrow slow divides by 64(n+1)
// [RULE7] async wide slow divides by 16(n+1)
// [RULE8] sync narrow divides by 4(n+1)
// [RULE9] n is the high:low pair, unsigned
// [RULE10] async narrow fast divides by 16(n+1)
// [RULE11] wide fast or sync divides 4(n+1)
// [RULE12] wide select picks 8 or 16 bits
// [RULE13] fast select used only when asynchronous
// [RULE14] mode bit picks sync or async
// [RULE15] sync master drives clock, slave receives
`timescale 1ns/100ps
`default_nettype none
`include "baud_gen_map.svh"

module baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic        aclk,          // 250 MHz system clock
    input  wire logic        aresetn,       // synchronous reset, active low
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    input  wire logic        shift_clk_i,   // shift clock pin, input
    output logic             shift_clk_o,   // shift clock pin, output
    output logic             shift_clk_oe,  // shift clock pin, drive enable
    output logic             bit_tick       // one pulse per bit time
);

    initial begin
        if (DIV_W != 16) begin
            $error("baud_gen divisor must be 16 bits wide");
        end
    end

    // ---------------- write channel ----------------
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    logic        awready_nxt;
    logic        wready_nxt;
    logic        bvalid_nxt;
    logic [1:0]  bresp_nxt;
    logic        aw_got_nxt;
    logic        w_got_nxt;

    wire aw_hs    = s_axi_awvalid & awready_r;
    wire w_hs     = s_axi_wvalid & wready_r;
    wire aw_have  = aw_got_r | aw_hs;
    wire w_have   = w_got_r | w_hs;
    wire do_write = aw_have & w_have & ~bvalid_r;

    wire [7:0]  wr_addr = aw_hs ? s_axi_awaddr : awaddr_r;
    wire [31:0] wr_data = w_hs ? s_axi_wdata : wdata_r;
    wire [3:0]  wr_strb = w_hs ? s_axi_wstrb : wstrb_r;
    wire        wr_lane0 = wr_strb[0];

    wire wr_sel_low  = (wr_addr == `BG_OFF_DIV_LOW);
    wire wr_sel_high = (wr_addr == `BG_OFF_DIV_HIGH);
    wire wr_sel_ctl  = (wr_addr == `BG_OFF_CONTROL);
    wire wr_sel_ro   = (wr_addr == `BG_OFF_STATUS) |
                       (wr_addr == `BG_OFF_TICKS) |
                       (wr_addr == `BG_OFF_DIV_USED);
    wire wr_mapped   = wr_sel_low | wr_sel_high | wr_sel_ctl | wr_sel_ro;

    wire wr_low  = do_write & wr_sel_low & wr_lane0;
    wire wr_high = do_write & wr_sel_high & wr_lane0;
    wire wr_ctl  = do_write & wr_sel_ctl & wr_lane0;

    assign aw_got_nxt  = aw_have & ~do_write;
    assign w_got_nxt   = w_have & ~do_write;
    assign bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
    assign bresp_nxt   = do_write ? (wr_mapped ? `BG_RESP_OKAY
                                               : `BG_RESP_SLVERR)
                                  : bresp_r;
    // each ready stays low until the response has been taken
    assign awready_nxt = ~aw_got_nxt & ~bvalid_nxt & ~do_write;
    assign wready_nxt  = ~w_got_nxt & ~bvalid_nxt & ~do_write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `BG_RESP_OKAY;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // ---------------- software registers ----------------
    logic [7:0]                 div_low_r;
    logic [7:0]                 div_high_r;
    logic [`BG_CTL_WIDTH-1:0]   ctl_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_low_r  <= `BG_RST_DIV_LOW;
            div_high_r <= `BG_RST_DIV_HIGH;
            ctl_r      <= `BG_RST_CONTROL;
        end else begin
            if (wr_low) begin
                div_low_r <= wr_data[7:0]; // RULE1
            end
            if (wr_high) begin
                div_high_r <= wr_data[7:0]; // RULE2
            end
            if (wr_ctl) begin
                ctl_r <= wr_data[`BG_CTL_WIDTH-1:0];
            end
        end
    end

    wire mode_sync   = ctl_r[`BG_CTL_SYNC_BIT];
    wire fast_rate   = ctl_r[`BG_CTL_FAST_BIT];
    wire wide_div    = ctl_r[`BG_CTL_WIDE_BIT];
    wire clk_master  = ctl_r[`BG_CTL_MASTER_BIT];

    // ---------------- rate selection ----------------
    wire [DIV_W-1:0] div_wide   = {div_high_r, div_low_r}; // RULE9
    wire [DIV_W-1:0] div_narrow = {8'h00, div_low_r}; // RULE5
    wire [DIV_W-1:0] div_used   = wide_div ? div_wide : div_narrow; // RULE12

    baud_gen_pkg::presc_t presc_sel;

    always_comb begin
        if (mode_sync) begin
            presc_sel = baud_gen_pkg::presc_4; // RULE8 RULE11 RULE14
        end else if (wide_div) begin
            presc_sel = fast_rate ? baud_gen_pkg::presc_4 // RULE11
                                  : baud_gen_pkg::presc_16; // RULE7
        end else begin
            presc_sel = fast_rate ? baud_gen_pkg::presc_16 // RULE10
                                  : baud_gen_pkg::presc_64; // RULE6
        end
    end

    logic [4:0] half_limit;

    // the prescaler runs at half the factor so the clock has two phases
    always_comb begin
        case (presc_sel) // RULE13
            baud_gen_pkg::presc_64: half_limit = `BG_HALF_64;
            baud_gen_pkg::presc_16: half_limit = `BG_HALF_16;
            baud_gen_pkg::presc_4:  half_limit = `BG_HALF_4;
            default:                half_limit = `BG_HALF_64;
        endcase
    end

    baud_gen_pkg::clk_src_t clk_src;

    assign clk_src = !mode_sync ? baud_gen_pkg::clk_none :
                     clk_master ? baud_gen_pkg::clk_master
                                : baud_gen_pkg::clk_slave;

    // a mode change also restarts, so no stale count runs past a new limit
    logic [`BG_CTL_WIDTH-1:0] ctl_seen_r;
    wire restart = wr_low | wr_high | (ctl_seen_r != ctl_r); // RULE3 RULE4

    // ---------------- divider chain ----------------
    logic             div_tick;
    logic [DIV_W-1:0] div_count;
    logic             half_tick;

    tick_divider #(
        .W (DIV_W)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (restart),
        .enable  (1'b1),
        .limit   (div_used),
        .tick    (div_tick),
        .count   (div_count)
    );

    tick_divider #(
        .W (5)
    ) u_presc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (restart),
        .enable  (div_tick),
        .limit   (half_limit),
        .tick    (half_tick),
        .count   ()
    );

    // ---------------- shift clock and bit tick ----------------
    logic pin_level;

    pin_sync u_pin (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_in   (shift_clk_i),
        .pin_sync (pin_level)
    );

    logic phase_r;
    logic pin_prev_r;
    logic ck_o_r;
    logic ck_oe_r;
    logic bit_tick_r;
    logic [15:0] tick_cnt_r;

    wire internal_bit = half_tick & phase_r;
    wire slave_rise   = pin_level & ~pin_prev_r;

    logic bit_nxt;

    always_comb begin
        case (clk_src)
            baud_gen_pkg::clk_none:   bit_nxt = internal_bit;
            baud_gen_pkg::clk_master: bit_nxt = internal_bit; // RULE15
            baud_gen_pkg::clk_slave:  bit_nxt = slave_rise; // RULE15
            default:                  bit_nxt = 1'b0;
        endcase
    end

    wire phase_nxt = restart ? 1'b0 : (phase_r ^ half_tick);
    wire ck_oe_nxt = (clk_src == baud_gen_pkg::clk_master);
    // clock pin idles low whenever it is not driven by this end
    wire ck_o_nxt  = ck_oe_nxt & phase_nxt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r    <= 1'b0;
            pin_prev_r <= 1'b0;
            ck_o_r     <= 1'b0;
            ck_oe_r    <= 1'b0;
            bit_tick_r <= 1'b0;
            tick_cnt_r <= 16'h0000;
            ctl_seen_r <= `BG_RST_CONTROL;
        end else begin
            phase_r    <= phase_nxt;
            pin_prev_r <= pin_level;
            ck_o_r     <= ck_o_nxt; // RULE15
            ck_oe_r    <= ck_oe_nxt; // RULE15
            bit_tick_r <= bit_nxt;
            ctl_seen_r <= ctl_r;
            if (bit_nxt) begin
                tick_cnt_r <= 16'(tick_cnt_r + 1'b1);
            end
        end
    end

    assign shift_clk_o  = ck_o_r;
    assign shift_clk_oe = ck_oe_r;
    assign bit_tick     = bit_tick_r;

    // ---------------- read channel ----------------
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    wire ar_hs = s_axi_arvalid & arready_r;

    wire rd_sel_low  = (s_axi_araddr == `BG_OFF_DIV_LOW);
    wire rd_sel_high = (s_axi_araddr == `BG_OFF_DIV_HIGH);
    wire rd_sel_ctl  = (s_axi_araddr == `BG_OFF_CONTROL);
    wire rd_sel_sta  = (s_axi_araddr == `BG_OFF_STATUS);
    wire rd_sel_tck  = (s_axi_araddr == `BG_OFF_TICKS);
    wire rd_sel_used = (s_axi_araddr == `BG_OFF_DIV_USED);
    wire rd_mapped   = rd_sel_low | rd_sel_high | rd_sel_ctl |
                       rd_sel_sta | rd_sel_tck | rd_sel_used;

    wire [31:0] status_word = {div_count, 14'h0000,
                               phase_r, ck_o_r | pin_level};

    wire [31:0] rd_word =
        rd_sel_low  ? {24'h00_0000, div_low_r} :
        rd_sel_high ? {24'h00_0000, div_high_r} :
        rd_sel_ctl  ? {28'h000_0000, ctl_r} :
        rd_sel_sta  ? status_word :
        rd_sel_tck  ? {16'h0000, tick_cnt_r} :
        rd_sel_used ? {16'h0000, div_used} : 32'h0000_0000;

    wire rvalid_nxt  = ar_hs | (rvalid_r & ~s_axi_rready);
    wire arready_nxt = ~rvalid_nxt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `BG_RESP_OKAY;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_hs) begin
                rdata_r <= rd_word;
                rresp_r <= rd_mapped ? `BG_RESP_OKAY : `BG_RESP_SLVERR;
            end
        end
    end

    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

endmodule

`default_nettype wire

// [baud_gen_chk.sv]
`timescale 1ns/100ps
`default_nettype none

module baud_gen_chk (
    input wire logic        aclk,          // clock
    input wire logic        aresetn,       // reset, active low
    input wire logic        s_axi_awvalid, // aw valid
    input wire logic        s_axi_awready, // aw ready
    input wire logic        s_axi_wvalid,  // w valid
    input wire logic        s_axi_wready,  // w ready
    input wire logic [1:0]  s_axi_bresp,   // b response
    input wire logic        s_axi_bvalid,  // b valid
    input wire logic        s_axi_bready,  // b ready
    input wire logic        s_axi_arvalid, // ar valid
    input wire logic        s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata,   // read data
    input wire logic        s_axi_rvalid,  // r valid
    input wire logic        s_axi_rready,  // r ready
    input wire logic        shift_clk_o,   // shift clock out
    input wire logic        shift_clk_oe,  // shift clock enable
    input wire logic        bit_tick       // bit pulse
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read response");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write open");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read open");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
        else $error("write channel not reopened");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not reopened");
    a_tick_pulse: assert property (bit_tick |=> !bit_tick)
        else $error("tick wider than one cycle");
    a_master_tick: assert property (bit_tick && shift_clk_oe
        |-> !shift_clk_o) else $error("tick not after falling clock");
    a_clk_half: assert property (shift_clk_oe && $changed(shift_clk_o)
        |=> $stable(shift_clk_o)) else $error("shift clock too fast");
endmodule

bind baud_gen baud_gen_chk baud_gen_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .shift_clk_o(shift_clk_o),
    .shift_clk_oe(shift_clk_oe), .bit_tick(bit_tick)
);

`default_nettype wire

// [baud_gen_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "baud_gen_map.svh"
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin \
    bad_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); end end

module baud_gen_bench;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, clk_pin = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        clk_o, clk_oe, tick;
    logic [1:0]  bresp, rresp;
    int          bad_count = 0, cmp_count = 0, n;
    logic [3:0]  ctl_tab [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hB, 4'hD};
    int          per_tab [6] = '{192, 48, 4144, 1036, 12, 1036};

    baud_gen #(.DIV_W(16)) baud_gen_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .shift_clk_i(clk_pin), .shift_clk_o(clk_o),
        .shift_clk_oe(clk_oe), .bit_tick(tick)
    );

    always #2 aclk = ~aclk;

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        `CHK("bresp", er, bresp)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        `CHK("rresp", er, rresp)
        `CHK("rdata", ed, rdata)
    endtask

    // cycles from now up to the next tick
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (!tick);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #200_000;
        bad_count++;
        test_done;
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rd(`BG_OFF_DIV_LOW, 32'h0000_0000, `BG_RESP_OKAY);
        rd(`BG_OFF_DIV_HIGH, 32'h0000_0000, `BG_RESP_OKAY);
        rd(`BG_OFF_CONTROL, 32'h0000_0000, `BG_RESP_OKAY);
        rd(8'h18, 32'h0000_0000, `BG_RESP_SLVERR);
        wr(8'h18, 32'h0000_0001, 4'hF, `BG_RESP_SLVERR);
        wr(`BG_OFF_DIV_LOW, 32'h0000_FF5A, 4'hF, `BG_RESP_OKAY);
        wr(`BG_OFF_DIV_HIGH, 32'h0000_00A5, 4'hF, `BG_RESP_OKAY);
        rd(`BG_OFF_DIV_LOW, 32'h0000_005A, `BG_RESP_OKAY);
        rd(`BG_OFF_DIV_HIGH, 32'h0000_00A5, `BG_RESP_OKAY);
        // byte lane off: register must keep its value
        wr(`BG_OFF_DIV_LOW, 32'h0000_0011, 4'h0, `BG_RESP_OKAY);
        rd(`BG_OFF_DIV_LOW, 32'h0000_005A, `BG_RESP_OKAY);
        $display("registers done");
        // high byte 1 must be ignored while narrow
        wr(`BG_OFF_DIV_LOW, 32'h0000_0002, 4'h1, `BG_RESP_OKAY);
        wr(`BG_OFF_DIV_HIGH, 32'h0000_0001, 4'h1, `BG_RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            wr(`BG_OFF_CONTROL, {28'h0, ctl_tab[i]}, 4'h1, `BG_RESP_OKAY);
            wait_tick(n);
            wait_tick(n);
            `CHK("period", per_tab[i], n)
            `CHK("drive", ctl_tab[i][0] & ctl_tab[i][3], clk_oe)
            // mid-bit the master clock stands high, otherwise low
            repeat (per_tab[i] / 2) @(posedge aclk);
            `CHK("clk", ctl_tab[i][0] & ctl_tab[i][3], clk_o)
            rd(`BG_OFF_DIV_USED, ctl_tab[i][2] ? 32'h0000_0102
                                               : 32'h0000_0002,
               `BG_RESP_OKAY);
        end
        $display("rates done");
        // async fast narrow, 48 cycles; restart 20 cycles into a bit
        wr(`BG_OFF_CONTROL, 32'h0000_0002, 4'h1, `BG_RESP_OKAY);
        wait_tick(n);
        repeat (20) @(posedge aclk);
        wr(`BG_OFF_DIV_LOW, 32'h0000_0002, 4'h1, `BG_RESP_OKAY);
        wait_tick(n);
        `CHK("restart low", 1'b1, n >= 40 && n <= 50)
        wait_tick(n);
        repeat (20) @(posedge aclk);
        wr(`BG_OFF_DIV_HIGH, 32'h0000_0001, 4'h1, `BG_RESP_OKAY);
        wait_tick(n);
        `CHK("restart high", 1'b1, n >= 40 && n <= 50)
        $display("restart done");
        // sync slave: ticks follow the external clock pin
        // master first, so the slave check sees the drive being dropped
        wr(`BG_OFF_CONTROL, 32'h0000_0009, 4'h1, `BG_RESP_OKAY);
        wr(`BG_OFF_CONTROL, 32'h0000_0001, 4'h1, `BG_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK("slave drive", 1'b0, clk_oe)
        clk_pin <= 1;
        wait_tick(n);
        `CHK("slave tick", 1'b1, n >= 3 && n <= 6)
        clk_pin <= 0;
        repeat (10) @(posedge aclk);
        $display("slave done");
        test_done;
    end
endmodule

`default_nettype wire
